/* File: hdl/dsor_soft_ramp.sv */
/*
 dac output soft ramp controller with per-path paged registers on axi4-lite.
 assumes trigger inputs are pulses on core_clk, except tx gate pins which
 are asynchronous and get synchronised here.
*/
// Functional notes
// - ramps start only when the path's master enable bit is one; a ramp under way runs on if it is cleared
// - ramps take 32 equal steps spanning 2^(rate+8) dac clocks
// - short-window power error starts ramp-down when its enable is set, default on
// - long-window power error starts ramp-down when its enable is set, default on
// - link receive error starts ramp-down when enabled, default off
// - sync rotation starts ramp-down when enabled and sync control bit 0 set
// - tx gate falling edge starts ramp-down when enabled, default on
// - software force-down at gain one starts ramp to zero
// - ramp controls are per path, selected by the page select register; sync control is shared by all paths
// - software force-up at gain zero starts ramp back to one
`timescale 1ns/10ps
module dsor_soft_ramp #(
  parameter int PATHS = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PATHS-1:0] shortPowerFault,
  input wire logic [PATHS-1:0] longPowerFault,
  input wire logic linkRxError,
  input wire logic syncRotation,
  input wire logic [PATHS-1:0] transmit_gate_pin,
  output logic [PATHS*6-1:0] pathGain
);
  // =====================================================================
  // write channel: address and data taken in either order
  logic [11:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic wLane_reg;
  logic doWrite;
  logic wrHit;

  assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // readies are flops: low means the beat is held until the answer goes out
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awAddr_reg <= 12'h000;
      wData_reg <= 32'h00000000;
      wLane_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awAddr_reg <= s_axi_awaddr[13:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wData_reg <= s_axi_wdata;
        wLane_reg <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? dsor_pkg::AXI_OKAY : dsor_pkg::AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // =====================================================================
  // registers: page, sync control, then paged per-path copies
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == dsor_pkg::PAGE_SEL_ADDR) ||
               (a == dsor_pkg::SYNC_CTRL_ADDR) ||
               (a == dsor_pkg::RAMP_GAIN_CTRL_ADDR) ||
               (a == dsor_pkg::RAMP_TRIG_SEL_ADDR) ||
               (a == dsor_pkg::RAMP_UP_CTRL_ADDR) ||
               (a == dsor_pkg::RAMP_STATUS_ADDR);
  endfunction : isMapped

  logic [7:0] pageSel_reg;
  logic [7:0] syncCtrl_reg;
  logic wrEn;
  logic [7:0] wByte;

  assign wrHit = isMapped(awAddr_reg);
  assign wrEn = doWrite && wrHit && wLane_reg;
  assign wByte = wData_reg[7:0];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pageSel_reg <= dsor_pkg::PAGE_SEL_RST;
      syncCtrl_reg <= dsor_pkg::SYNC_CTRL_RST;
    end else if (wrEn) begin
      if (awAddr_reg == dsor_pkg::PAGE_SEL_ADDR) pageSel_reg <= wByte;
      if (awAddr_reg == dsor_pkg::SYNC_CTRL_ADDR) syncCtrl_reg <= wByte;
    end
  end

  // =====================================================================
  // tx gate pins: two-flop synchroniser then edge detect on the second flop
  logic [PATHS-1:0] txgMeta_reg;
  logic [PATHS-1:0] txgSync_reg;
  logic [PATHS-1:0] txgLast_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txgMeta_reg <= '0;
      txgSync_reg <= '0;
      txgLast_reg <= '0;
    end else begin
      txgMeta_reg <= transmit_gate_pin;
      txgSync_reg <= txgMeta_reg;
      txgLast_reg <= txgSync_reg;
    end
  end

  // =====================================================================
  // per-path register copies and ramp engines
  logic [7:0] gainCtrl [PATHS];
  logic [7:0] trigSel [PATHS];
  logic [7:0] upCtrl [PATHS];
  logic [5:0] gainVal [PATHS];
  dsor_pkg::dsor_state_type stateVal [PATHS];

  genvar p;
  generate
    for (p = 0; p < PATHS; p++) begin : g_path
      logic [7:0] gainCtrl_reg;
      logic [7:0] trigSel_reg;
      logic [7:0] upCtrl_reg;
      logic sel;
      logic forceDown;
      logic forceUp;
      logic downReq;
      logic [5:0] gainOut;
      dsor_pkg::dsor_state_type stOut;

      assign sel = pageSel_reg[p];
      assign forceDown = trigSel_reg[dsor_pkg::FORCE_DOWN_BIT];
      assign forceUp = upCtrl_reg[dsor_pkg::FORCE_UP_BIT];
      assign downReq =
        (trigSel_reg[dsor_pkg::SHORT_EN_BIT] && shortPowerFault[p]) ||
        (trigSel_reg[dsor_pkg::LONG_EN_BIT] && longPowerFault[p]) ||
        (trigSel_reg[dsor_pkg::LINK_EN_BIT] && linkRxError) ||
        (trigSel_reg[dsor_pkg::ROT_EN_BIT] && syncCtrl_reg[dsor_pkg::SYNC_ROT_BIT]
          && syncRotation) ||
        (trigSel_reg[dsor_pkg::TXG_EN_BIT] && txgLast_reg[p] && !txgSync_reg[p]) ||
        forceDown;

      // force bits self-clear once the ramp they asked for has started
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          gainCtrl_reg <= dsor_pkg::GAIN_CTRL_RST;
          trigSel_reg <= dsor_pkg::TRIG_SEL_RST;
          upCtrl_reg <= dsor_pkg::UP_CTRL_RST;
        end else begin
          if (stOut == dsor_pkg::RAMP_FALL) trigSel_reg[dsor_pkg::FORCE_DOWN_BIT] <= 1'b0;
          if (stOut == dsor_pkg::RAMP_RISE) upCtrl_reg[dsor_pkg::FORCE_UP_BIT] <= 1'b0;
          if (wrEn && sel) begin
            if (awAddr_reg == dsor_pkg::RAMP_GAIN_CTRL_ADDR)
              gainCtrl_reg <= wByte & 8'h87;
            if (awAddr_reg == dsor_pkg::RAMP_TRIG_SEL_ADDR)
              trigSel_reg <= wByte & 8'hCF;
            if (awAddr_reg == dsor_pkg::RAMP_UP_CTRL_ADDR)
              upCtrl_reg <= wByte & 8'hC0;
          end
        end
      end

      dsor_ramp_path u_ramp (
        .core_clk(core_clk),
        .rst(rst),
        .masterEn(gainCtrl_reg[dsor_pkg::MASTER_EN_BIT]),
        .rateCode(gainCtrl_reg[dsor_pkg::RATE_LSB +: dsor_pkg::RATE_W]),
        .downReq(downReq),
        .upReq(forceUp),
        .gain(gainOut),
        .state(stOut)
      );

      assign gainCtrl[p] = gainCtrl_reg;
      assign trigSel[p] = trigSel_reg;
      assign upCtrl[p] = upCtrl_reg;
      assign gainVal[p] = gainOut;
      assign stateVal[p] = stOut;
    end
  endgenerate

  // =====================================================================
  // read path: lowest selected path answers paged reads
  logic [7:0] pagedByte;
  logic [31:0] rdWord;
  logic [11:0] rdIdx;

  assign rdIdx = s_axi_araddr[13:2];

  always_comb begin
    pagedByte = 8'h00;
    for (int i = PATHS - 1; i >= 0; i--) begin
      if (pageSel_reg[i]) begin
        case (rdIdx)
          dsor_pkg::RAMP_GAIN_CTRL_ADDR: pagedByte = gainCtrl[i];
          dsor_pkg::RAMP_TRIG_SEL_ADDR: pagedByte = trigSel[i];
          dsor_pkg::RAMP_UP_CTRL_ADDR: pagedByte = upCtrl[i];
          dsor_pkg::RAMP_STATUS_ADDR: pagedByte = {stateVal[i], gainVal[i]};
          default: pagedByte = 8'h00;
        endcase
      end
    end
    if (rdIdx == dsor_pkg::PAGE_SEL_ADDR) pagedByte = pageSel_reg;
    if (rdIdx == dsor_pkg::SYNC_CTRL_ADDR) pagedByte = syncCtrl_reg;
  end

  assign rdWord = {24'h000000, pagedByte};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdWord;
      s_axi_rresp <= isMapped(rdIdx) ? dsor_pkg::AXI_OKAY : dsor_pkg::AXI_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // =====================================================================
  // gain outputs, registered
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pathGain <= {PATHS{dsor_pkg::GAIN_FULL}};
    end else begin
      for (int i = 0; i < PATHS; i++) pathGain[i*6 +: 6] <= gainVal[i];
    end
  end
endmodule : dsor_soft_ramp

/* File: shared/dsor_pkg.sv */
/*
 package for the dac output soft ramp block: register offsets, field positions,
 reset values and ramp constants. assumes a 32-bit axi4-lite register bus.
*/
package dsor_pkg;
  // =====================================================================
  // register indices: the bus byte address is four times the index
  localparam logic [11:0] SYNC_CTRL_ADDR = 12'h03B;
  localparam logic [11:0] PAGE_SEL_ADDR = 12'h008;
  localparam logic [11:0] RAMP_GAIN_CTRL_ADDR = 12'h580;
  localparam logic [11:0] RAMP_TRIG_SEL_ADDR = 12'h581;
  localparam logic [11:0] RAMP_UP_CTRL_ADDR = 12'h582;
  localparam logic [11:0] RAMP_STATUS_ADDR = 12'h5A0;
  // =====================================================================
  // field positions
  localparam int MASTER_EN_BIT = 7;
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 3;
  localparam int SHORT_EN_BIT = 7;
  localparam int LONG_EN_BIT = 6;
  localparam int LINK_EN_BIT = 3;
  localparam int ROT_EN_BIT = 2;
  localparam int TXG_EN_BIT = 1;
  localparam int FORCE_DOWN_BIT = 0;
  localparam int FORCE_UP_BIT = 7;
  localparam int SYNC_ROT_BIT = 0;
  // =====================================================================
  // reset values
  localparam logic [7:0] GAIN_CTRL_RST = 8'h00;
  localparam logic [7:0] TRIG_SEL_RST = 8'hC6;
  localparam logic [7:0] UP_CTRL_RST = 8'h00;
  localparam logic [7:0] SYNC_CTRL_RST = 8'h00;
  localparam logic [7:0] PAGE_SEL_RST = 8'h01;
  // =====================================================================
  // ramp shape, bus response codes and ramp states
  localparam int RAMP_STEPS = 32;
  localparam int GAIN_W = 6;
  localparam logic [GAIN_W-1:0] GAIN_FULL = 6'h20;
  localparam int RAMP_EXP_BASE = 8;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {RAMP_IDLE_HIGH, RAMP_FALL, RAMP_IDLE_LOW, RAMP_RISE} dsor_state_type;
endpackage : dsor_pkg

/* File: hdl/dsor_ramp_path.sv */
/*
 one dac path gain ramp: holds gain 0..32 and steps it on a divided enable.
 assumes triggers are single-cycle pulses on core_clk.
*/
`timescale 1ns/10ps
module dsor_ramp_path (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic masterEn,
  input wire logic [2:0] rateCode,
  input wire logic downReq,
  input wire logic upReq,
  output logic [5:0] gain,
  output dsor_pkg::dsor_state_type state
);
  // =====================================================================
  // step divider: one step per 2^(code+8)/32 = 2^(code+3) clocks
  logic [10:0] divCnt_reg;
  logic [10:0] divLimit;
  logic stepEn;
  logic [5:0] gain_reg;
  dsor_pkg::dsor_state_type state_reg;
  dsor_pkg::dsor_state_type state_next;
  logic [5:0] gain_next;
  logic ramping;

  // shift amount widened to 4 bits so codes 5..7 do not wrap
  assign divLimit = 11'((32'h1 << (4'(rateCode) + 4'(dsor_pkg::RAMP_EXP_BASE - 5))) - 32'h1);
  assign ramping = (state_reg == dsor_pkg::RAMP_FALL) || (state_reg == dsor_pkg::RAMP_RISE);
  assign stepEn = ramping && (divCnt_reg == divLimit);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      divCnt_reg <= 11'h000;
    end else if (!ramping || stepEn) begin
      divCnt_reg <= 11'h000;
    end else begin
      divCnt_reg <= divCnt_reg + 11'h001;
    end
  end

  // =====================================================================
  // ramp state; triggers during fall or at zero do nothing
  always_comb begin
    state_next = state_reg;
    gain_next = gain_reg;
    case (state_reg)
      dsor_pkg::RAMP_IDLE_HIGH: begin
        if (masterEn && downReq) state_next = dsor_pkg::RAMP_FALL;
      end
      dsor_pkg::RAMP_FALL: begin
        if (stepEn) begin
          gain_next = gain_reg - 6'h01;
          if (gain_reg == 6'h01) state_next = dsor_pkg::RAMP_IDLE_LOW;
        end
      end
      dsor_pkg::RAMP_IDLE_LOW: begin
        if (masterEn && upReq) state_next = dsor_pkg::RAMP_RISE;
      end
      dsor_pkg::RAMP_RISE: begin
        if (stepEn) begin
          gain_next = gain_reg + 6'h01;
          if (gain_reg == dsor_pkg::GAIN_FULL - 6'h01) state_next = dsor_pkg::RAMP_IDLE_HIGH;
        end
      end
      default: state_next = dsor_pkg::RAMP_IDLE_HIGH;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= dsor_pkg::RAMP_IDLE_HIGH;
      gain_reg <= dsor_pkg::GAIN_FULL;
    end else begin
      state_reg <= state_next;
      gain_reg <= gain_next;
    end
  end

  assign gain = gain_reg;
  assign state = state_reg;
endmodule : dsor_ramp_path

/* File: test/dsor_checker.sv */
/* checker for dsor_soft_ramp: gain steps of path 0 and bus answers.
 assumes it is bound to dsor_soft_ramp and sees its ports only. */
`timescale 1ns/10ps
module dsor_checker #(
  parameter int PATHS = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_arready,
  input wire logic [PATHS*6-1:0] pathGain
);
  // ====================
  // gain relations
  wire [5:0] g = pathGain[5:0];
  // clocks since the last gain change; slowest step is 1024 clocks
  logic [5:0] gLast_reg;
  logic [10:0] gapCnt_reg;
  always_ff @(posedge core_clk) begin
    gLast_reg <= g;
    if (rst || g != gLast_reg) begin
      gapCnt_reg <= 11'h000;
    end else if (gapCnt_reg != 11'h7FF) begin
      gapCnt_reg <= gapCnt_reg + 11'h001;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  gain_range_a: assert property (g <= 6'h20)
    else $error("gain above unity");
  step_size_a: assert property ($changed(g) |-> (g - $past(g)) inside {6'h01, 6'h3F})
    else $error("gain step not one");
  // rate code 0 is the fastest: eight clocks per step
  step_gap_a: assert property ($changed(g) |=> $stable(g) [*7])
    else $error("gain steps too close");
  ramp_cont_a: assert property (g != 6'h00 && g != 6'h20 |-> gapCnt_reg < 11'h400)
    else $error("ramp stalled");
  no_reverse_a: assert property (g < $past(g) |=> (g <= $past(g)) [*8])
    else $error("ramp-down reversed");
  // ====================
  // bus answers
  bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  rresp_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  read_gate_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read taken while answering");
endmodule : dsor_checker
bind dsor_soft_ramp dsor_checker #(.PATHS(PATHS)) i_chk (.core_clk, .rst, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_arready, .pathGain);

/* File: test/test_dsor_soft_ramp.sv */
/* bench for dsor_soft_ramp: axi4-lite tasks, trigger pulses, timed ramps.
 assumes PATHS of 2; dsor_pkg gives register indices, byte address is four times. */
`timescale 1ns/10ps
module test_dsor_soft_ramp;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic [13:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  // bits: short0 long0 link sync gate0 short1 long1 gate1
  logic [7:0] trig = 8'h00;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [11:0] pathGain;
  int errors = 0, n_compared = 0;
  initial forever #12.5 core_clk = ~core_clk;
  dsor_soft_ramp #(.PATHS(2)) i_dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .shortPowerFault({trig[5], trig[0]}), .longPowerFault({trig[6], trig[1]}),
    .linkRxError(trig[2]), .syncRotation(trig[3]),
    .transmit_gate_pin(~{trig[7], trig[4]}), .pathGain(pathGain));
  // ====================
  // tasks
  task automatic end_of_test;
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge core_clk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) break;
    end
    check(32'(s_axi_bresp), 32'(dsor_pkg::AXI_OKAY));
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge core_clk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) break;
    end
    if (r === dsor_pkg::AXI_OKAY) check(s_axi_rdata, e);
    check(32'(s_axi_rresp), 32'(r));
    s_axi_rready <= 1'h0;
  endtask : rd
  // one trigger pulse, then either a held gain or a ramp to zero and back
  task automatic trial(input int k, input logic [7:0] sel, input logic ramp);
    wr(dsor_pkg::RAMP_TRIG_SEL_ADDR, sel);
    @(posedge core_clk);
    trig <= 8'h01 << k;
    @(posedge core_clk);
    trig <= 8'h00;
    repeat (300) @(posedge core_clk);
    check(32'(pathGain[5:0]), ramp ? 32'h00 : 32'h20);
    if (ramp) begin
      wr(dsor_pkg::RAMP_UP_CTRL_ADDR, 8'h80);
      repeat (300) @(posedge core_clk);
      check(32'(pathGain[5:0]), 32'h20);
    end
  endtask : trial
  // counts clocks from the first step to the last one
  task automatic timed(input logic [11:0] a, input logic [7:0] d, input logic [5:0] g0,
    input int c);
    int n;
    n = 0;
    wr(a, d);
    repeat (5000) begin
      @(posedge core_clk);
      if (pathGain[5:0] !== g0) break;
    end
    while (pathGain[5:0] !== (dsor_pkg::GAIN_FULL - g0) && n < 5000) begin
      @(posedge core_clk);
      n++;
      trig <= (n == 100 && g0 == 6'h20) ? 8'h01 : 8'h00;
    end
    check(32'(n), 32'(31 << (c + 3)));
  endtask : timed
  // ====================
  // sequence
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    check(32'(pathGain), 32'h820);
    rd(dsor_pkg::RAMP_GAIN_CTRL_ADDR, 32'h00, dsor_pkg::AXI_OKAY);
    rd(dsor_pkg::RAMP_TRIG_SEL_ADDR, 32'hC6, dsor_pkg::AXI_OKAY);
    rd(dsor_pkg::PAGE_SEL_ADDR, 32'h01, dsor_pkg::AXI_OKAY);
    rd(12'h5FC, 32'h00, dsor_pkg::AXI_SLVERR);
    trial(0, 8'hC6, 1'h0);
    wr(dsor_pkg::RAMP_GAIN_CTRL_ADDR, 8'h80);
    wr(dsor_pkg::PAGE_SEL_ADDR, 8'h02);
    rd(dsor_pkg::RAMP_GAIN_CTRL_ADDR, 32'h00, dsor_pkg::AXI_OKAY);
    wr(dsor_pkg::PAGE_SEL_ADDR, 8'h01);
    rd(dsor_pkg::RAMP_GAIN_CTRL_ADDR, 32'h80, dsor_pkg::AXI_OKAY);
    trial(5, 8'hC6, 1'h0);
    trial(0, 8'hC6, 1'h1);
    trial(0, 8'h46, 1'h0);
    trial(1, 8'hC6, 1'h1);
    trial(1, 8'h86, 1'h0);
    trial(2, 8'hC6, 1'h0);
    trial(2, 8'hCE, 1'h1);
    trial(3, 8'hC6, 1'h0);
    wr(dsor_pkg::SYNC_CTRL_ADDR, 8'h01);
    trial(3, 8'hC6, 1'h1);
    trial(3, 8'hC2, 1'h0);
    trial(4, 8'hC6, 1'h1);
    trial(4, 8'hC4, 1'h0);
    trial(8, 8'hC7, 1'h1);
    for (int c = 0; c < 3; c++) begin
      wr(dsor_pkg::RAMP_GAIN_CTRL_ADDR, 8'h80 | 8'(c));
      timed(dsor_pkg::RAMP_TRIG_SEL_ADDR, 8'hC7, 6'h20, c);
      timed(dsor_pkg::RAMP_UP_CTRL_ADDR, 8'h80, 6'h00, c);
    end
    check(32'(pathGain[11:6]), 32'h20);
    wr(dsor_pkg::PAGE_SEL_ADDR, 8'h02);
    wr(dsor_pkg::RAMP_GAIN_CTRL_ADDR, 8'h80);
    trial(5, 8'hC6, 1'h0);
    check(32'(pathGain[11:6]), 32'h00);
    rd(dsor_pkg::RAMP_STATUS_ADDR, 32'h80, dsor_pkg::AXI_OKAY);
    end_of_test();
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    errors++;
    end_of_test();
  end
endmodule : test_dsor_soft_ramp
